// File: rtl/cctg_top.sv
`timescale 1ns/10ps
module cctg_top
  import cctg_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  input wire logic MCLK_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  input wire logic BUS_SELECT_I,
  input wire logic POWER_DEFAULT_SEL_I,
  input wire logic PCM_FRAME_SYNC_I,
  output logic [7:0] TONE_WORD_O,
  output logic [14:0] RX_TONE_WORD_O,
  output logic TONE_STROBE_O,
  output logic BUZZER_PDM_OUTPUT_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Register read value; top bit of aux shows master clock activity
  function automatic logic [7:0] rd_val(input cctg_regs_t regs, input logic det, input logic [7:0] ptr);
    if (ptr == REG_AUX)
      rd_val = {det, regs[REG_AUX[2:0]][6:0]};
    else if (ptr < 8'(NUM_REGS))
      rd_val = regs[ptr[2:0]];
    else
      rd_val = 8'h00;
  endfunction : rd_val

  // Phase step per frame, scaled by the resolution field
  function automatic logic [9:0] tone_inc(input logic [7:0] code, input logic [1:0] res);
    unique case (res)
      2'b00: tone_inc = {2'b00, code};
      2'b01: tone_inc = {1'b0, code, 1'b0};
      default: tone_inc = {code, 2'b00};
    endcase
  endfunction : tone_inc

  // Quarter-wave lookup with mirror and sign; code zero silences the tone
  function automatic logic [7:0] tone_samp(input logic [7:0] code, input logic [9:0] ph, input logic hi);
    logic [3:0] idx;
    logic [7:0] mag;
    idx = ph[8] ? ~ph[7:4] : ph[7:4];
    mag = hi ? {1'b0, HIGH_QTAB[idx]} : {2'b00, LOW_QTAB[idx]};
    if (code == 8'h00)
      tone_samp = 8'h00;
    else if (ph[9])
      tone_samp = -mag;
    else
      tone_samp = mag;
  endfunction : tone_samp

  ////////////////////////////////////////////////////////////////////////////
  // Control port, system clock domain

  cctg_bus_t r;
  cctg_bus_t n;
  cctg_tone_t t;
  cctg_tone_t m;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic bus_sel;
  logic busy;
  logic mclk_det;
  logic [7:0] nxt_rd;

  // Edge and condition decode from the second synchroniser stage
  assign scl_rise = r.scl_s[1] & ~r.scl_s[2];
  assign scl_fall = ~r.scl_s[1] & r.scl_s[2];
  assign bus_start = r.scl_s[1] & r.scl_s[2] & r.sda_s[2] & ~r.sda_s[1];
  assign bus_stop = r.scl_s[1] & r.scl_s[2] & ~r.sda_s[2] & r.sda_s[1];
  assign bus_sel = r.sel_s[1];
  assign busy = r.req != r.ack_s[1];
  assign mclk_det = r.det_cnt != DET_WIN;
  assign nxt_rd = rd_val(r.regs, mclk_det, r.ptr + 8'h01);

  // Slave engine, register bank and hand-off toward the tone domain
  always_comb
  begin
    n = r;
    n.scl_s = {r.scl_s[1:0], SCL_I};
    n.sda_s = {r.sda_s[1:0], SDA_I};
    n.sel_s = {r.sel_s[0], BUS_SELECT_I};
    n.strap_s = {r.strap_s[0], POWER_DEFAULT_SEL_I};
    n.ack_s = {r.ack_s[0], t.ack};
    n.hb_s = {r.hb_s[1:0], t.hb[3]};
    n.sda_lvl = 1'b0;
    // Master clock watchdog
    if (r.hb_s[2] != r.hb_s[1])
      n.det_cnt = 7'h00;
    else if (r.det_cnt != DET_WIN)
      n.det_cnt = r.det_cnt + 7'h01;
    // Snapshot goes out only when the previous one was taken
    if (r.pend && !busy)
    begin
      n.cfg_x.mode = r.regs[REG_MODE[2:0]];
      n.cfg_x.aux = r.regs[REG_AUX[2:0]];
      n.cfg_x.high_tone_code_field = r.regs[REG_HIGH[2:0]];
      n.cfg_x.low_tone_code_field = r.regs[REG_LOW[2:0]];
      n.req = ~r.req;
      n.pend = 1'b0;
    end
    if (!bus_sel)
    begin
      n.st = BUS_IDLE;
      n.sda_oe = 1'b0;
    end
    else if (bus_start)
    begin
      n.st = BUS_ADDR;
      n.bits = 4'h0;
      n.sda_oe = 1'b0;
    end
    else if (bus_stop)
    begin
      n.st = BUS_IDLE;
      n.sda_oe = 1'b0;
    end
    else
    begin
      unique case (r.st)
        BUS_IDLE: ;
        BUS_ADDR, BUS_INDEX, BUS_WDATA:
          if (scl_rise && r.bits != BYTE_BITS)
          begin
            n.shreg = {r.shreg[6:0], r.sda_s[1]};
            n.bits = r.bits + 4'h1;
          end
          else if (scl_fall && r.bits == BYTE_BITS)
          begin
            n.bits = 4'h0;
            n.sda_oe = 1'b1;
            if (r.st == BUS_ADDR)
            begin
              n.rd = r.shreg[0];
              n.st = BUS_ADDR_ACK;
              if (r.shreg[7:1] != DEV_SEL_WR[7:1])
              begin
                n.st = BUS_IDLE;
                n.sda_oe = 1'b0;
              end
            end
            else if (r.st == BUS_INDEX)
            begin
              n.ptr = r.shreg;
              n.st = BUS_INDEX_ACK;
            end
            else
            begin
              if (r.ptr < 8'(NUM_REGS))
              begin
                n.regs[r.ptr[2:0]] = r.shreg;
                n.pend = 1'b1;
              end
              n.st = BUS_WDATA_ACK;
            end
          end
        BUS_ADDR_ACK, BUS_INDEX_ACK, BUS_WDATA_ACK:
          if (scl_fall)
          begin
            n.sda_oe = 1'b0;
            n.bits = 4'h0;
            if (r.st == BUS_WDATA_ACK)
            begin
              n.ptr = r.ptr + 8'h01;
              n.st = BUS_WDATA;
            end
            else if (r.st == BUS_INDEX_ACK)
              n.st = BUS_WDATA;
            else if (!r.rd)
              n.st = BUS_INDEX;
            else
            begin
              n.shreg = rd_val(r.regs, mclk_det, r.ptr);
              n.sda_oe = ~n.shreg[7];
              n.st = BUS_RDATA;
            end
          end
        BUS_RDATA:
          if (scl_rise)
            n.bits = r.bits + 4'h1;
          else if (scl_fall && r.bits == BYTE_BITS)
          begin
            n.sda_oe = 1'b0;
            n.st = BUS_RACK;
          end
          else if (scl_fall)
          begin
            n.shreg = {r.shreg[6:0], 1'b0};
            n.sda_oe = ~r.shreg[6];
          end
        BUS_RACK:
          if (scl_rise && r.sda_s[1])
            n.st = BUS_IDLE;
          else if (scl_rise)
            n.bits = 4'h0;
          else if (scl_fall && r.bits == 4'h0)
          begin
            n.ptr = r.ptr + 8'h01;
            n.shreg = nxt_rd;
            n.sda_oe = ~nxt_rd[7];
            n.st = BUS_RDATA;
          end
        default: n.st = BUS_IDLE; // Unused codes fall back to idle
      endcase
    end
    if (!RESET_N_I)
    begin
      n.st = BUS_IDLE;
      n.bits = 4'h0;
      n.shreg = 8'h00;
      n.ptr = 8'h00;
      n.rd = 1'b0;
      n.sda_oe = 1'b0;
      n.pend = 1'b1;
      n.req = 1'b0;
      n.cfg_x = '0;
      n.det_cnt = 7'h00;
      n.regs = {ZERO_RST, ZERO_RST, ZERO_RST, RX_RST, TX_RST, MODE_RST,
        r.strap_s[1] ? PWR_RST_B : PWR_RST_A};
    end
  end

  always_ff @(posedge CLOCK_I)
  begin
    r <= n;
  end

  assign SDA_O = r.sda_lvl;
  assign SDA_OE_O = r.sda_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Tone generator and buzzer modulator, master clock domain

  logic load;
  logic frame;
  logic [16:0] pdm_in;

  assign load = t.req_s[1] != t.ack;
  assign frame = t.sync_s[1] & ~t.sync_s[2];
  assign pdm_in = {{2{t.rx_word[14]}}, t.rx_word};

  // Iterative lookup, sum, padding and first-order pulse-density modulator
  always_comb
  begin
    m = t;
    m.rst_s = {t.rst_s[0], RESET_N_I};
    m.req_s = {t.req_s[1:0], r.req};
    m.sync_s = {t.sync_s[1:0], PCM_FRAME_SYNC_I};
    m.hb = t.hb + 4'h1;
    m.strobe = 1'b0;
    unique case (t.st)
      TG_IDLE:
        if (load)
        begin
          m.cfg = r.cfg_x;
          m.ack = t.req_s[1];
          m.ph_lo = 10'h000;
          m.ph_hi = 10'h000;
          m.st = TG_LOW;
        end
        else if (frame)
        begin
          m.ph_lo = t.ph_lo + tone_inc(t.cfg.low_tone_code_field, t.cfg.aux[AUX_LRES_LSB +: 2]);
          m.ph_hi = t.ph_hi + tone_inc(t.cfg.high_tone_code_field, t.cfg.aux[AUX_HRES_LSB +: 2]);
          m.st = TG_LOW;
        end
      TG_LOW:
      begin
        m.s_lo = tone_samp(t.cfg.low_tone_code_field, t.ph_lo, 1'b0);
        m.st = TG_HIGH;
      end
      TG_HIGH:
      begin
        m.s_hi = tone_samp(t.cfg.high_tone_code_field, t.ph_hi, 1'b1);
        m.st = TG_OUT;
      end
      TG_OUT:
      begin
        m.word = t.s_lo + t.s_hi;
        m.rx_word = {m.word, 7'h00};
        m.strobe = 1'b1;
        m.st = TG_IDLE;
      end
    endcase
    m.pdm_acc = t.pdm_acc + pdm_in - (t.pdm_bit ? PDM_FS : -PDM_FS);
    m.pdm_bit = ~m.pdm_acc[16];
    m.buzzer_pdm_output = t.cfg.mode[MODE_BUZZ_BIT] & m.pdm_bit;
    if (!t.rst_s[1])
    begin
      m.ack = 1'b0;
      m.cfg = '0;
      m.st = TG_IDLE;
      m.ph_lo = 10'h000;
      m.ph_hi = 10'h000;
      m.s_lo = 8'h00;
      m.s_hi = 8'h00;
      m.word = 8'h00;
      m.rx_word = 15'h0000;
      m.pdm_acc = 17'h0_0000;
      m.pdm_bit = 1'b0;
      m.buzzer_pdm_output = 1'b0;
      m.strobe = 1'b0;
      m.hb = 4'h0;
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    t <= m;
  end

  assign TONE_WORD_O = t.word;
  assign RX_TONE_WORD_O = t.rx_word;
  assign TONE_STROBE_O = t.strobe;
  assign BUZZER_PDM_OUTPUT_O = t.buzzer_pdm_output;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RESET_N_I);

  property p_ack_sel;
    (r.st == BUS_ADDR && bus_sel && !bus_start && !bus_stop && scl_fall && r.bits == BYTE_BITS
      && r.shreg[7:1] == DEV_SEL_WR[7:1]) |=> (r.sda_oe && r.st == BUS_ADDR_ACK);
  endproperty
  a_ack_sel: assert property (p_ack_sel) else $error("select byte not acknowledged");

  property p_foreign;
    (r.st == BUS_ADDR && scl_fall && r.bits == BYTE_BITS && r.shreg[7:1] != DEV_SEL_WR[7:1])
      |=> (!r.sda_oe && r.st == BUS_IDLE);
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign select byte answered");

  property p_desel;
    !bus_sel |=> (r.st == BUS_IDLE && !r.sda_oe) [*2];
  endproperty
  a_desel: assert property (p_desel) else $error("active while deselected");

  property p_stop;
    (bus_sel && bus_stop && !bus_start) |=> r.st == BUS_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not honoured");

  property p_sda_low;
    ($changed(r.sda_oe) && $past(bus_sel) && bus_sel) |-> !r.scl_s[2];
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("data changed while clock high");

  property p_sample;
    (r.st == BUS_INDEX && bus_sel && !bus_start && !bus_stop && scl_rise && r.bits < BYTE_BITS)
      |=> r.shreg[0] == $past(r.sda_s[1]);
  endproperty
  a_sample: assert property (p_sample) else $error("bit not sampled on clock high");

  property p_write;
    (r.st == BUS_WDATA && bus_sel && !bus_start && !bus_stop && scl_fall && r.bits == BYTE_BITS
      && r.ptr == REG_HIGH) |=> (r.regs[REG_HIGH[2:0]] == $past(r.shreg) && r.pend);
  endproperty
  a_write: assert property (p_write) else $error("tone code write lost");

  property p_nack;
    (r.st == BUS_RACK && bus_sel && !bus_start && !bus_stop && scl_rise && r.sda_s[1])
      |=> (r.st == BUS_IDLE && !r.sda_oe) ##1 !r.sda_oe;
  endproperty
  a_nack: assert property (p_nack) else $error("data line held after last read");

  property p_lookup;
    @(posedge MCLK_I) disable iff (!t.rst_s[1]) (t.st == TG_IDLE && load) |-> ##4 t.strobe;
  endproperty
  a_lookup: assert property (p_lookup) else $error("tone load produced no sample");

  property p_pad;
    @(posedge MCLK_I) disable iff (!t.rst_s[1]) t.strobe |-> (t.rx_word == {t.word, 7'h00});
  endproperty
  a_pad: assert property (p_pad) else $error("receive word padding wrong");

  property p_peak;
    @(posedge MCLK_I) disable iff (!t.rst_s[1])
      t.strobe |-> ($signed(t.s_lo) <= 31 && $signed(t.s_lo) >= -31 && $signed(t.word) <= 70);
  endproperty
  a_peak: assert property (p_peak) else $error("tone sample over peak");

  c_write: cover property (r.st == BUS_WDATA_ACK && r.ptr == REG_LOW);
  c_read_end: cover property (r.st == BUS_RACK && scl_rise && r.sda_s[1]);
  c_tone: cover property (@(posedge MCLK_I) t.strobe && t.word == 8'h46);

endmodule : cctg_top

// File: rtl/cctg_pkg.sv
// Behaviour
// - Tones reach every output path; only the buzzer pin has an enable, mode bit 3.
// - High and low tone codes sit in separate registers, each written alone.
// - Writing a tone register starts a lookup giving 6-bit low, 7-bit high samples.
// - High tone amplitude is 2 dB above low tone amplitude.
// - Low sample peaks at 31, widened to 8 bits by two leading zeros.
// - Low peak on receive path is 3968 against full scale 16383.
// - High sample peaks at 39, widened to 8 bits by one leading zero.
// - High 8-bit word gains seven trailing zeros, peak 4992 on 15 bits.
// - Summed dual tone peaks at 70, giving receive word 8960.
// - Enabled buzzer pin carries a pulse-density stream of the summed tone word.
// - Slave only, and responds only while bus select input is high.
// - Select byte E2 hex means write, E3 hex means read.
// - Data line changes only while clock low; high-phase changes are start or stop.
// - Data fall with clock high is start, rise is stop; transfers use both.
// - One clock pulse per bit, sampled while the clock is high.
// - Device pulls data low during the ninth clock after each addressed byte.
// - Master withholds last read acknowledge; device releases data for stop.
// - Sample rate follows the 8 kHz frame sync input.
// - Tone and modulator timing derive from the master clock.
// - Two-bit auxiliary fields pick 7.8125, 15.625 or 31.25 Hz resolution.
package cctg_pkg;
  localparam logic [7:0] DEV_SEL_WR = 8'hE2;
  localparam logic [7:0] DEV_SEL_RD = 8'hE3;
  localparam int NUM_REGS = 7;
  localparam logic [7:0] REG_POWER = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h01;
  localparam logic [7:0] REG_TXGAIN = 8'h02;
  localparam logic [7:0] REG_RXGAIN = 8'h03;
  localparam logic [7:0] REG_HIGH = 8'h04;
  localparam logic [7:0] REG_LOW = 8'h05;
  localparam logic [7:0] REG_AUX = 8'h06;
  localparam logic [7:0] PWR_RST_A = 8'hF6;
  localparam logic [7:0] PWR_RST_B = 8'h9B;
  localparam logic [7:0] MODE_RST = 8'h02;
  localparam logic [7:0] TX_RST = 8'h40;
  localparam logic [7:0] RX_RST = 8'hA0;
  localparam logic [7:0] ZERO_RST = 8'h00;
  localparam int MODE_BUZZ_BIT = 3;
  localparam int AUX_LRES_LSB = 2;
  localparam int AUX_HRES_LSB = 4;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int RX_PAD = 7;
  localparam logic [6:0] DET_WIN = 7'h40;
  localparam logic signed [16:0] PDM_FS = 17'sh0_4000;
  // Quarter-wave magnitudes, entry 15 first
  localparam logic [15:0][5:0] LOW_QTAB = {6'h1F, 6'h1F, 6'h1E, 6'h1D, 6'h1C, 6'h1B, 6'h19, 6'h17,
    6'h15, 6'h12, 6'h10, 6'h0D, 6'h0A, 6'h08, 6'h05, 6'h02};
  localparam logic [15:0][6:0] HIGH_QTAB = {7'h27, 7'h27, 7'h26, 7'h25, 7'h23, 7'h21, 7'h1F, 7'h1D,
    7'h1A, 7'h17, 7'h14, 7'h11, 7'h0D, 7'h09, 7'h06, 7'h02};
  typedef logic [NUM_REGS-1:0][7:0] cctg_regs_t;
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] aux;
    logic [7:0] high_tone_code_field;
    logic [7:0] low_tone_code_field;
  } cctg_cfg_t;
  typedef enum logic [3:0] {
    BUS_IDLE = 4'b0000, BUS_ADDR = 4'b0001, BUS_ADDR_ACK = 4'b0010, BUS_INDEX = 4'b0011,
    BUS_INDEX_ACK = 4'b0100, BUS_WDATA = 4'b0101, BUS_WDATA_ACK = 4'b0110,
    BUS_RDATA = 4'b0111, BUS_RACK = 4'b1000
  } cctg_bus_st_t;
  typedef enum logic [1:0] {TG_IDLE = 2'b00, TG_LOW = 2'b01, TG_HIGH = 2'b10, TG_OUT = 2'b11} cctg_tg_st_t;
  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [1:0] sel_s;
    logic [1:0] strap_s;
    logic [1:0] ack_s;
    logic [2:0] hb_s;
    cctg_bus_st_t st;
    logic [3:0] bits;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic rd;
    logic sda_oe;
    logic sda_lvl;
    logic pend;
    logic req;
    cctg_regs_t regs;
    cctg_cfg_t cfg_x;
    logic [6:0] det_cnt;
  } cctg_bus_t;
  typedef struct packed {
    logic [1:0] rst_s;
    logic [2:0] req_s;
    logic [2:0] sync_s;
    logic ack;
    cctg_cfg_t cfg;
    cctg_tg_st_t st;
    logic [9:0] ph_lo;
    logic [9:0] ph_hi;
    logic [7:0] s_lo;
    logic [7:0] s_hi;
    logic [7:0] word;
    logic [14:0] rx_word;
    logic strobe;
    logic [16:0] pdm_acc;
    logic pdm_bit;
    logic buzzer_pdm_output;
    logic [3:0] hb;
  } cctg_tone_t;
endpackage : cctg_pkg

// File: dv/cctg_bus_master.sv
`timescale 1ns/10ps
module cctg_bus_master
  import cctg_pkg::*;
(
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // Bus starts idle with both lines released
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Six system clocks per bus phase keeps every phase above 200 ns
  task automatic gap();
    repeat (6) @(posedge clk_i);
    #1;
  endtask : gap
  // One pulse per bit: data set while clock low, sampled at the end of clock high
  task automatic bit_cycle(input logic b, output logic s);
    sda_o = b;
    gap();
    scl_o = 1'b1;
    gap();
    s = sda_i;
    scl_o = 1'b0;
    gap();
  endtask : bit_cycle
  // Start or repeated start: data falls while clock high
  task automatic start_cond();
    sda_o = 1'b1;
    gap();
    scl_o = 1'b1;
    gap();
    sda_o = 1'b0;
    gap();
    scl_o = 1'b0;
    gap();
  endtask : start_cond
  // Stop: data rises while clock high, bus left idle
  task automatic stop_cond();
    sda_o = 1'b0;
    gap();
    scl_o = 1'b1;
    gap();
    sda_o = 1'b1;
    gap();
  endtask : stop_cond
  // Byte out MSB first, then a ninth pulse with the line released for the acknowledge
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cycle(b[i], s);
    bit_cycle(1'b1, s);
    ack = ~s;
  endtask : put_byte
  // Byte in; the master acknowledges unless last, and reports the line during that pulse
  task automatic get_byte(input logic last, output logic [7:0] d, output logic rel);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_cycle(1'b1, s);
      d[i] = s;
    end
    bit_cycle(last, rel);
  endtask : get_byte
  // Select, index and data bytes in one transfer; the master sets the byte count
  task automatic write_reg(input logic [7:0] sel, input logic [7:0] idx, input logic [7:0] data, output logic ok);
    logic a;
    logic b;
    logic c;
    start_cond();
    put_byte(sel, a);
    put_byte(idx, b);
    put_byte(data, c);
    stop_cond();
    ok = a & b & c;
  endtask : write_reg
  // Index set by a write select, then a repeated start and one read byte
  task automatic read_reg(input logic [7:0] idx, output logic [7:0] d, output logic ok, output logic rel);
    logic a;
    logic b;
    logic c;
    start_cond();
    put_byte(DEV_SEL_WR, a);
    put_byte(idx, b);
    start_cond();
    put_byte(DEV_SEL_RD, c);
    get_byte(1'b1, d, rel);
    stop_cond();
    ok = a & b & c;
  endtask : read_reg
  // Two bytes in one read: the first acknowledged by the master, the second ends the transfer
  task automatic read_two(input logic [7:0] idx, output logic [15:0] d, output logic ok);
    logic a;
    logic b;
    logic c;
    logic r0;
    logic r1;
    start_cond();
    put_byte(DEV_SEL_WR, a);
    put_byte(idx, b);
    start_cond();
    put_byte(DEV_SEL_RD, c);
    get_byte(1'b0, d[15:8], r0);
    get_byte(1'b1, d[7:0], r1);
    stop_cond();
    ok = a & b & c & r1;
  endtask : read_two
endmodule : cctg_bus_master

// File: dv/tb_codec_control_port_tone_gen.sv
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module tb_codec_control_port_tone_gen
  import cctg_pkg::*;
;
  typedef struct {logic [7:0] idx; logic [7:0] wdata; logic [7:0] rexp;} cctg_row_t;
  cctg_row_t rows [8] = '{'{8'h00, 8'hA5, 8'hA5}, '{8'h01, 8'h3C, 8'h3C}, '{8'h02, 8'h7F, 8'h7F},
    '{8'h03, 8'h96, 8'h96}, '{8'h04, 8'hD1, 8'hD1}, '{8'h05, 8'h59, 8'h59}, '{8'h06, 8'h7E, 8'hFE},
    '{8'h07, 8'h55, 8'h00}};
  logic [7:0] rst_exp [7] = '{8'hF6, 8'h02, 8'h40, 8'hA0, 8'h00, 8'h00, 8'h80};
  logic clk, mclk, rst_n, scl, sda_m, sda_line, bus_sel, strap, fsync;
  logic sda_o, sda_oe, strobe, buzz, ok, rel;
  logic [7:0] tone_word, rd;
  logic [15:0] rd2;
  logic [14:0] rx_word;
  logic signed [7:0] wmax, wmin;
  logic [7:0] seq [$];
  logic [7:0] ref_q [$];
  int fail_count, n_compared, n_ones;
  ////////////////////////////////////////////////////////////////////////////////
  // Open-drain data line with pull-up
  assign sda_line = sda_m & !(sda_oe === 1'b1 && sda_o === 1'b0);
  cctg_top uut (.CLOCK_I(clk), .RESET_N_I(rst_n), .MCLK_I(mclk), .SCL_I(scl), .SDA_I(sda_line),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe), .BUS_SELECT_I(bus_sel), .POWER_DEFAULT_SEL_I(strap),
    .PCM_FRAME_SYNC_I(fsync), .TONE_WORD_O(tone_word), .RX_TONE_WORD_O(rx_word),
    .TONE_STROBE_O(strobe), .BUZZER_PDM_OUTPUT_O(buzz));
  cctg_bus_master master (.clk_i(clk), .sda_i(sda_line), .scl_o(scl), .sda_o(sda_m));
  ////////////////////////////////////////////////////////////////////////////////
  // System clock 40 ns, master clock 15 ns with its own phase
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    mclk = 1'b0;
    #3;
    forever #7.5 mclk = ~mclk;
  end
  // Device may move the data line only while the bus clock is low
  always @(sda_oe)
    if (rst_n === 1'b1)
      `CHK(scl, 1'b0)
  // Every strobe: receive word is the tone word with seven zeros below; track peaks
  // Sampled mid-cycle so the outputs have settled; an unknown buzzer bit counts as a one
  always @(negedge mclk)
  begin
    if (buzz !== 1'b0)
      n_ones++;
    if (strobe === 1'b1)
    begin
      `CHK(rx_word, {tone_word, 7'h00})
      seq.push_back(tone_word);
      if ($signed(tone_word) > wmax)
        wmax = tone_word;
      if ($signed(tone_word) < wmin)
        wmin = tone_word;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // Reset held long enough for both clock domains
  task automatic do_reset();
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask : do_reset
  task automatic wr(input logic [7:0] idx, input logic [7:0] data);
    master.write_reg(DEV_SEL_WR, idx, data, ok);
    `CHK(ok, 1'b1)
  endtask : wr
  task automatic chk_read(input logic [7:0] idx, input logic [7:0] exp);
    master.read_reg(idx, rd, ok, rel);
    `CHK(ok, 1'b1)
    `CHK(rd, exp)
    `CHK(rel, 1'b1)
  endtask : chk_read
  // Frame sync pulses, far apart compared with the lookup
  task automatic frames(input int n);
    repeat (n)
    begin
      @(posedge mclk);
      #1 fsync = 1'b1;
      repeat (4) @(posedge mclk);
      #1 fsync = 1'b0;
      repeat (36) @(posedge mclk);
    end
  endtask : frames
  // Load resolution and both codes, check the first word, then clear the record
  task automatic tone_load(input logic [7:0] aux, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] w0);
    wr(REG_AUX, aux);
    wr(REG_LOW, lo);
    wr(REG_HIGH, hi);
    repeat (60) @(posedge clk);
    `CHK(tone_word, w0)
    seq.delete();
    wmax = 8'h80;
    wmin = 8'h7F;
    n_ones = 0;
  endtask : tone_load
  // Watchdog well beyond the expected run of about 1.3 ms
  initial
  begin
    #2500000;
    fail_count++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    bus_sel = 1'b1;
    strap = 1'b0;
    fsync = 1'b0;
    do_reset();
    // Table of register writes with read-back, aux top bit read-only, index 7 dropped
    foreach (rows[i])
    begin
      wr(rows[i].idx, rows[i].wdata);
      chk_read(rows[i].idx, rows[i].rexp);
    end
    do_reset();
    for (int i = 0; i < 7; i++)
      chk_read(i[7:0], rst_exp[i]);
    // Two-byte read walks the index forward across a master acknowledge
    master.read_two(REG_TXGAIN, rd2, ok);
    `CHK(ok, 1'b1)
    `CHK(rd2, {TX_RST, RX_RST})
    // Low tone alone, buzzer disabled
    tone_load(8'h00, 8'd89, 8'h00, 8'h02);
    frames(64);
    `CHK(wmax, 8'h1F)
    `CHK(wmin, 8'hE1)
    `CHK(n_ones, 0)
    // High tone alone, larger peak
    tone_load(8'h00, 8'h00, 8'd209, 8'h02);
    frames(64);
    `CHK(wmax, 8'h27)
    `CHK(wmin, 8'hD9)
    // Dual tone with buzzer enabled
    wr(REG_MODE, 8'h0A);
    tone_load(8'h00, 8'd89, 8'd155, 8'h04);
    frames(64);
    `CHK(wmax <= 8'sh46, 1'b1)
    `CHK(n_ones > 0, 1'b1)
    // Halved code at doubled resolution must give the same samples
    for (int r = 0; r < 3; r++)
    begin
      tone_load({2'b00, r[1:0], r[1:0], 2'b00}, 8'd60 >> r, 8'd60 >> r, 8'h04);
      frames(24);
      `CHK(seq.size(), 24)
      if (r == 0)
        ref_q = seq;
      else
        foreach (ref_q[i])
          `CHK(seq[i], ref_q[i])
    end
    // Deselected device and wrong select byte are both ignored
    bus_sel = 1'b0;
    master.write_reg(DEV_SEL_WR, REG_LOW, 8'h11, ok);
    `CHK(ok, 1'b0)
    bus_sel = 1'b1;
    master.write_reg(8'hE4, REG_LOW, 8'h22, ok);
    `CHK(ok, 1'b0)
    chk_read(REG_LOW, 8'h0F);
    // Strap picks the other power control default
    strap = 1'b1;
    do_reset();
    chk_read(REG_POWER, 8'h9B);
    print_verdict();
  end
endmodule : tb_codec_control_port_tone_gen
